// File: verilog/rss_consts.vh
// constants for the reset and strap sampling block
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH
`define RSS_SYNC_STAGES     2
`define RSS_NUMERICS_DELAY  4
`define RSS_DRIVE_CYCLES    1
`define RSS_CNT_W           3
`endif

// File: verilog/rss_sync.v
// two-flop synchroniser for a single level
`timescale 1ns/1ps
module rss_sync #(
  parameter RESET_VAL = 1'b0
) (
  input  wire i_ref_clk,
  input  wire i_d,
  output wire o_q
);
  reg meta_q;
  reg sync_q;
  // no reset here: this stage carries the reset itself
  always @(posedge i_ref_clk) begin
    meta_q <= i_d;
    sync_q <= meta_q;
  end
  assign o_q = sync_q;
endmodule // rss_sync

// File: verilog/rss_reset_strap.v
// reset synchronisation, bus abort and reset-time strap sampling
// Summary of operation
// - synchronise reset input before internal use
// - reset stops activity, returns initial state
// - abort bus cycle: drive inactive, then float
// - strap pins become pulled-up inputs in reset
// - both chip selects low selects isolation mode
// - read strap low selects queue status mode
// - test high at reset, low four later
`timescale 1ns/1ps
`include "rss_consts.vh"
module rss_reset_strap #(
  parameter NUM_DELAY = `RSS_NUMERICS_DELAY,
  parameter DRV_CYC   = `RSS_DRIVE_CYCLES
) (
  // clock and reset
  input  wire i_ref_clk,
  input  wire i_nrst,
  input  wire i_reset_input_n,
  // bus activity from the core
  input  wire i_bus_cycle_active,
  input  wire i_read_strobe_n,
  input  wire i_upper_mem_select_n,
  input  wire i_lower_mem_select_n,
  input  wire i_mid_select0_n,
  input  wire i_mid_select1_n,
  input  wire i_bus_lock_n,
  // strap pin inputs
  input  wire i_read_strobe_or_queue_strap,
  input  wire i_upper_mem_select_pin,
  input  wire i_lower_mem_select_pin,
  input  wire i_test_busy_pin,
  // pin drive outputs
  output reg  o_read_strobe_or_queue_strap,
  output reg  o_read_strobe_or_queue_strap_oe,
  output reg  o_upper_mem_select,
  output reg  o_upper_mem_select_oe,
  output reg  o_lower_mem_select,
  output reg  o_lower_mem_select_oe,
  output reg  o_mid_select0_coproc_request,
  output reg  o_mid_select0_coproc_request_oe,
  output reg  o_mid_select1_coproc_fault,
  output reg  o_mid_select1_coproc_fault_oe,
  output reg  o_bus_lock_n,
  output reg  o_bus_lock_oe,
  output wire o_pullup_en,
  // internal reset and modes
  output wire o_core_reset,
  output reg  o_bus_abort,
  output reg  o_isolation_test_mode,
  output reg  o_queue_status_mode,
  output reg  o_numerics_mode
);
  localparam ST_RUN   = 3'b001;
  localparam ST_DRIVE = 3'b010;
  localparam ST_FLOAT = 3'b100;

  wire                  rst_sync_n;
  reg                   rst_dly_q;
  reg  [2:0]            state_q;
  reg  [2:0]            state_d;
  reg  [`RSS_CNT_W-1:0] cnt_q;
  reg  [`RSS_CNT_W-1:0] num_cnt_q;
  reg                   num_wait_q;
  wire                  in_reset;

  // pin sampled only through the synchroniser
  rss_sync #(.RESET_VAL(1'b0)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_d       (i_reset_input_n & i_nrst),
    .o_q       (rst_sync_n)
  );
  // relies on a running clock and a held-low reset at power-up
  assign in_reset     = ~rst_sync_n;
  assign o_core_reset = in_reset;
  assign o_pullup_en  = in_reset;

  always @(posedge i_ref_clk) begin
    rst_dly_q <= rst_sync_n;
  end

  // abort sequence: drive inactive for DRV_CYC, then float
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (in_reset)
          state_d = i_bus_cycle_active ? ST_DRIVE : ST_FLOAT;
      end
      ST_DRIVE: begin
        if (cnt_q >= DRV_CYC[`RSS_CNT_W-1:0] - 3'h1)
          state_d = ST_FLOAT;
      end
      ST_FLOAT: begin
        if (!in_reset)
          state_d = ST_RUN;
      end
      default: state_d = ST_FLOAT;
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      state_q <= ST_FLOAT;
      cnt_q   <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_q == ST_DRIVE) ? cnt_q + 3'h1 : 3'h0;
    end
  end

  // pin drivers; floating lets the weak pull-ups show strap levels
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_read_strobe_or_queue_strap    <= 1'b1;
      o_read_strobe_or_queue_strap_oe <= 1'b0;
      o_upper_mem_select              <= 1'b1;
      o_upper_mem_select_oe           <= 1'b0;
      o_lower_mem_select              <= 1'b1;
      o_lower_mem_select_oe           <= 1'b0;
      o_mid_select0_coproc_request    <= 1'b1;
      o_mid_select0_coproc_request_oe <= 1'b0;
      o_mid_select1_coproc_fault      <= 1'b1;
      o_mid_select1_coproc_fault_oe   <= 1'b0;
      o_bus_lock_n                    <= 1'b1;
      o_bus_lock_oe                   <= 1'b0;
      o_bus_abort                     <= 1'b0;
    end else begin
      o_bus_abort <= (state_d == ST_DRIVE);
      if (state_d == ST_RUN) begin
        o_read_strobe_or_queue_strap    <= i_read_strobe_n;
        o_upper_mem_select              <= i_upper_mem_select_n;
        o_lower_mem_select              <= i_lower_mem_select_n;
        o_mid_select0_coproc_request    <= i_mid_select0_n;
        o_mid_select1_coproc_fault      <= i_mid_select1_n;
        o_bus_lock_n                    <= i_bus_lock_n;
      end else begin
        o_read_strobe_or_queue_strap    <= 1'b1;
        o_upper_mem_select              <= 1'b1;
        o_lower_mem_select              <= 1'b1;
        o_mid_select0_coproc_request    <= 1'b1;
        o_mid_select1_coproc_fault      <= 1'b1;
        o_bus_lock_n                    <= 1'b1;
      end
      o_read_strobe_or_queue_strap_oe <= (state_d != ST_FLOAT);
      o_upper_mem_select_oe           <= (state_d != ST_FLOAT);
      o_lower_mem_select_oe           <= (state_d != ST_FLOAT);
      o_mid_select0_coproc_request_oe <= (state_d != ST_FLOAT);
      o_mid_select1_coproc_fault_oe   <= (state_d != ST_FLOAT);
      o_bus_lock_oe                   <= (state_d != ST_FLOAT);
    end
  end

  // bus lock is never sampled as a strap; a low there is undefined

  // isolation and queue straps latched on the release edge, numerics NUM_DELAY later, all kept until next reset
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_isolation_test_mode <= 1'b0;
      o_queue_status_mode   <= 1'b0;
      o_numerics_mode       <= 1'b0;
      num_wait_q            <= 1'b0;
      num_cnt_q             <= 3'h0;
    end else if (in_reset) begin
      o_isolation_test_mode <= 1'b0;
      o_queue_status_mode   <= 1'b0;
      o_numerics_mode       <= 1'b0;
      num_wait_q            <= 1'b0;
      num_cnt_q             <= 3'h0;
    end else if (!rst_dly_q) begin
      o_isolation_test_mode <= ~i_upper_mem_select_pin & ~i_lower_mem_select_pin;
      o_queue_status_mode   <= ~i_read_strobe_or_queue_strap;
      num_wait_q            <= i_test_busy_pin;
      num_cnt_q             <= 3'h1;
    end else if (num_wait_q) begin
      // test pin checked exactly NUM_DELAY clocks after the release edge
      if (num_cnt_q == NUM_DELAY[`RSS_CNT_W-1:0]) begin
        o_numerics_mode <= ~i_test_busy_pin;
        num_wait_q      <= 1'b0;
      end else begin
        num_cnt_q <= num_cnt_q + 3'h1;
      end
    end
  end
endmodule // rss_reset_strap

// File: tb/rss_board.sv
// board reset source and strap drivers
`timescale 1ns/1ps
module rss_board (
  input  wire i_ref_clk, i_hold, i_upper_low, i_lower_low, i_queue_low, i_num,
  output wire o_reset_input_n, o_upper_pin, o_lower_pin, o_queue_pin, o_test_pin
);
  reg [3:0] cnt_q = 4'hF;
  always @(posedge i_ref_clk)
    cnt_q <= i_hold ? 4'h0 : (cnt_q == 4'hF ? cnt_q : cnt_q + 4'h1);
  // straps kept a while after release, then left to the pull-ups
  wire strap_on = cnt_q < 4'h9;
  assign o_reset_input_n = !i_hold;
  assign o_upper_pin = !(strap_on && i_upper_low);
  assign o_lower_pin = !(strap_on && i_lower_low);
  assign o_queue_pin = !(strap_on && i_queue_low);
  assign o_test_pin = !(i_num && cnt_q > 4'h4);
  // lock pin never driven by the board
endmodule // rss_board

// File: tb/rss_reset_strap_monitor.sv
// assertions for reset and strap sampling
`timescale 1ns/1ps
module rss_reset_strap_monitor (
  input wire i_ref_clk, i_nrst, i_reset_input_n, i_test_busy_pin,
  input wire i_upper_mem_select_pin, i_lower_mem_select_pin, i_read_strobe_or_queue_strap,
  input wire o_pullup_en, o_core_reset, o_bus_abort, o_bus_lock_n, o_bus_lock_oe,
  input wire o_isolation_test_mode, o_queue_status_mode, o_numerics_mode
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_rel; $fell(o_core_reset); endsequence
  sequence s_abort; o_bus_lock_oe && o_bus_lock_n ##1 !o_bus_lock_oe; endsequence
  a_lock_inactive: assert property ($past(o_pullup_en) |-> o_bus_lock_n)
    else $error("lock active in reset");
  a_float_in_reset: assert property (o_core_reset [*3] |-> !o_bus_lock_oe)
    else $error("pin driven in reset");
  a_abort_steps: assert property (o_bus_abort |-> s_abort)
    else $error("abort steps");
  a_sync_delay: assert property ($fell(i_reset_input_n) && !o_core_reset |->
    !o_core_reset ##[1:2] o_core_reset)
    else $error("reset sync");
  a_iso_strap: assert property (s_rel |-> ##2 o_isolation_test_mode ==
    (!i_upper_mem_select_pin && !i_lower_mem_select_pin))
    else $error("isolation mode");
  a_queue_strap: assert property (s_rel |-> ##2
    o_queue_status_mode == !i_read_strobe_or_queue_strap)
    else $error("queue mode");
  a_num_enable: assert property (s_rel ##0 i_test_busy_pin ##4 !i_test_busy_pin |->
    ##1 o_numerics_mode)
    else $error("numerics mode");
  a_num_refuse: assert property (s_rel ##4 i_test_busy_pin |-> ##1 !o_numerics_mode)
    else $error("numerics without low test");
  a_modes_hold: assert property (!o_core_reset [*8] |-> $stable(o_isolation_test_mode)
    && $stable(o_queue_status_mode) && $stable(o_numerics_mode))
    else $error("mode changed");
endmodule // rss_reset_strap_monitor
bind rss_reset_strap rss_reset_strap_monitor u_mon (.*);

// File: tb/tb_rss_reset_strap.sv
// testbench for reset and strap sampling
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD %0t %h %h", $time, a, e); end end
module tb_rss_reset_strap;
  reg clk = 0, nrst = 0, hold = 1, bus = 0, num = 0;
  reg [2:0] st = 0;
  reg [5:0] core_n = 6'h3F;
  int checks = 0, n_mismatch = 0, k;
  wire rp, up, lp, qp, tp, lk, lk_oe, um, um_oe, pu, cr, ab, iso, qs, nm;
  wire rs, rs_oe, ls, ls_oe, m0, m0_oe, m1, m1_oe;
  wire [5:0] pins = {lk, m1, m0, ls, um, rs};
  wire [5:0] oes = {lk_oe, m1_oe, m0_oe, ls_oe, um_oe, rs_oe};
  initial forever #25 clk = ~clk;
  rss_board board (.i_ref_clk(clk), .i_hold(hold), .i_upper_low(st[0]), .i_lower_low(st[1]),
    .i_queue_low(st[2]), .i_num(num), .o_reset_input_n(rp), .o_upper_pin(up),
    .o_lower_pin(lp), .o_queue_pin(qp), .o_test_pin(tp));
  rss_reset_strap uut (.i_ref_clk(clk), .i_nrst(nrst), .i_reset_input_n(rp),
    .i_bus_cycle_active(bus), .i_read_strobe_n(core_n[0]), .i_upper_mem_select_n(core_n[1]),
    .i_lower_mem_select_n(core_n[2]), .i_mid_select0_n(core_n[3]),
    .i_mid_select1_n(core_n[4]), .i_bus_lock_n(core_n[5]),
    .i_read_strobe_or_queue_strap(qp), .i_upper_mem_select_pin(up),
    .i_lower_mem_select_pin(lp), .i_test_busy_pin(tp),
    .o_read_strobe_or_queue_strap(rs), .o_read_strobe_or_queue_strap_oe(rs_oe),
    .o_upper_mem_select(um), .o_upper_mem_select_oe(um_oe), .o_lower_mem_select(ls),
    .o_lower_mem_select_oe(ls_oe), .o_mid_select0_coproc_request(m0),
    .o_mid_select0_coproc_request_oe(m0_oe), .o_mid_select1_coproc_fault(m1),
    .o_mid_select1_coproc_fault_oe(m1_oe), .o_bus_lock_n(lk), .o_bus_lock_oe(lk_oe),
    .o_pullup_en(pu), .o_core_reset(cr), .o_bus_abort(ab), .o_isolation_test_mode(iso),
    .o_queue_status_mode(qs), .o_numerics_mode(nm));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    cyc(2);
    nrst = 1;
    // every strap combination, each followed by a short run
    for (k = 0; k < 16; k++) begin
      {num, st} = k[3:0];
      hold = 1;
      cyc(6);
      `CHK({cr, pu, iso, qs, nm}, 5'h18)
      `CHK({pins, oes}, 12'hFC0)
      hold = 0;
      cyc(12);
      `CHK({iso, qs, nm}, {st[0] & st[1], st[2], num})
      core_n = {k[0], ~k[4:0]};
      cyc(1);
      `CHK({pins, oes}, {core_n, 6'h3F})
    end
    // warm reset in mid bus cycle with controls active
    bus = 1;
    core_n = 6'h00;
    hold = 1;
    cyc(1);
    `CHK(cr, 1'b0)
    for (k = 0; k < 8 && ab !== 1'b1; k++) cyc(1);
    `CHK({ab, lk, lk_oe}, 3'h7)
    `CHK({ab, pins, oes}, 13'h1FFF)
    cyc(1);
    `CHK({ab, lk_oe, pu}, 3'h1)
    `CHK({ab, oes, pu, iso, qs, nm}, 11'h008)
    // final release after the warm reset: straps taken again, pins driven again
    hold = 0;
    cyc(12);
    `CHK({iso, qs, nm, cr}, 4'hE)
    `CHK(oes, 6'h3F)
    conclude;
  end
endmodule // tb_rss_reset_strap
